// ===== sef_map.svh
// Offsets, field positions, opcodes and timing figures of the serial EEPROM command front end.
`ifndef SEF_MAP_SVH
`define SEF_MAP_SVH
`define SEF_OP_MASK 8'hf7
`define SEF_OP_SET_WEL 8'h06
`define SEF_OP_CLR_WEL 8'h04
`define SEF_OP_STAT_RD 8'h05
`define SEF_OP_STAT_WR 8'h01
`define SEF_OP_ARR_RD 8'h03
`define SEF_OP_ARR_WR 8'h02
`define SEF_ST_PEN 7
`define SEF_ST_BP_HI 3
`define SEF_ST_BP_LO 2
`define SEF_ST_WEL 1
`define SEF_ST_BUSY 0
`define SEF_ST_BUSY_VALUE 8'hff
`define SEF_ST_UNUSED_VALUE 3'h0
`define SEF_BIT_LAST 3'h7
`define SEF_ADDR_BYTES 2'h3
`define SEF_T_WC_US 8000
`define SEF_CLK_MHZ 40
`endif

// ===== sef_pkg.sv
// Types shared by the serial EEPROM command front end.
package sef_pkg;
  typedef struct packed {
    logic select_n;
    logic sck;
    logic si;
    logic pause_n;
    logic wp_n;
  } sef_pins_t;
  typedef struct packed {
    logic pin_protect_enable_bit;
    logic block_protect_hi;
    logic block_protect_lo;
  } sef_prot_t;
  typedef enum logic [2:0] {
    SEF_IDLE,
    SEF_OPCODE,
    SEF_STAT_OUT,
    SEF_STAT_IN,
    SEF_ADDR,
    SEF_RD_DATA,
    SEF_WR_DATA,
    SEF_IGNORE
  } sef_state_t;
endpackage

// ===== sef_front_end.sv
// Serial EEPROM command front end with its receive FIFO.
`timescale 1ns/1ps
`include "sef_map.svh"

module sef_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Draining side.
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least two.");
    end
  endgenerate
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = wr_ptr_reg == rd_ptr_reg;
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module sef_front_end #(
  parameter int WRITE_CYCLE_CLKS = `SEF_T_WC_US * `SEF_CLK_MHZ,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Serial link pins, all from outside this clock domain.
  input wire sef_pkg::sef_pins_t pins_i,
  output logic so_o,
  output logic so_oe_o,
  // Received address and write data bytes.
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // Array read data supplied by the array side.
  input wire logic [7:0] rd_byte_i,
  output logic rd_req_o,
  // Internal write cycle in progress.
  output logic busy_o
);
  import sef_pkg::*;

  generate
    if (WRITE_CYCLE_CLKS < 1 || FIFO_DEPTH < 2)
    begin : g_bad_params
      $error("Write cycle length and FIFO depth are out of range.");
    end
  endgenerate

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    op_is = (op & `SEF_OP_MASK) == code;
  endfunction

  // Two-flop synchronisers; the first stage feeds only the second.
  sef_pins_t pins_s1_reg;
  sef_pins_t pins_s2_reg;
  logic sck_d_reg;
  logic sel_d_reg;
  logic wp_d_reg;
  sef_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic so_reg;
  logic drive_reg;
  logic [1:0] addr_cnt_reg;
  logic data_seen_reg;
  logic [7:0] stat_in_reg;
  logic stat_got_reg;
  logic wp_abort_reg;
  logic wel_reg;
  sef_prot_t prot_reg;
  logic busy_reg;
  logic [31:0] wc_cnt_reg;
  logic push_reg;
  logic [7:0] push_data_reg;
  logic rd_req_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;

  wire selected = !pins_s2_reg.select_n;
  wire sel_fall = selected && sel_d_reg;
  wire sel_rise = !selected && !sel_d_reg;
  wire paused = !pins_s2_reg.pause_n;
  wire active = selected && !paused;
  wire sck_rise = active && pins_s2_reg.sck && !sck_d_reg;
  wire sck_fall = active && !pins_s2_reg.sck && sck_d_reg;
  wire byte_done = sck_rise && (bit_cnt_reg == `SEF_BIT_LAST);
  wire [7:0] rx_byte = {shift_reg[6:0], pins_s2_reg.si};
  wire hw_protect = prot_reg.pin_protect_enable_bit && !pins_s2_reg.wp_n;
  wire wp_fell = !pins_s2_reg.wp_n && wp_d_reg;
  wire [7:0] status_byte = busy_reg ? `SEF_ST_BUSY_VALUE :
    {prot_reg.pin_protect_enable_bit, `SEF_ST_UNUSED_VALUE, prot_reg.block_protect_hi,
     prot_reg.block_protect_lo, wel_reg, busy_reg};
  wire stat_commit = sel_rise && state_reg == SEF_STAT_IN && stat_got_reg && wel_reg && !wp_abort_reg &&
    !hw_protect;
  wire arr_commit = sel_rise && state_reg == SEF_WR_DATA && data_seen_reg && wel_reg;
  wire wc_done = busy_reg && wc_cnt_reg == 32'h1;
  wire tx_state = state_reg == SEF_STAT_OUT || state_reg == SEF_RD_DATA;

  // Opcode decode; an internal write cycle lets only the status read through.
  sef_state_t op_state;
  always_comb
  begin
    op_state = SEF_IGNORE;
    if (op_is(rx_byte, `SEF_OP_STAT_RD))
    begin
      op_state = SEF_STAT_OUT;
    end
    else if (busy_reg)
    begin
      op_state = SEF_IGNORE;
    end
    else if (op_is(rx_byte, `SEF_OP_STAT_WR))
    begin
      op_state = SEF_STAT_IN;
    end
    else if (op_is(rx_byte, `SEF_OP_ARR_RD) || op_is(rx_byte, `SEF_OP_ARR_WR))
    begin
      op_state = SEF_ADDR;
    end
  end
  wire is_write_op = op_is(rx_byte, `SEF_OP_ARR_WR);

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pins_s1_reg <= '{select_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
      pins_s2_reg <= '{select_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      wp_d_reg <= 1'b1;
    end
    else
    begin
      pins_s1_reg <= pins_i;
      pins_s2_reg <= pins_s1_reg;
      sck_d_reg <= pins_s2_reg.sck;
      sel_d_reg <= !selected;
      wp_d_reg <= pins_s2_reg.wp_n;
    end
  end

  // Serial sequencer. Pause freezes everything but the WP fall watch and the select handling, and keeps the frame's position.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= SEF_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      addr_cnt_reg <= 2'h0;
      data_seen_reg <= 1'b0;
      stat_in_reg <= 8'h00;
      stat_got_reg <= 1'b0;
      wp_abort_reg <= 1'b0;
      tx_reg <= 8'h00;
      drive_reg <= 1'b0;
      rd_req_reg <= 1'b0;
    end
    else
    begin
      rd_req_reg <= 1'b0;
      if (!selected)
      begin
        state_reg <= SEF_IDLE;
        drive_reg <= 1'b0;
      end
      else if (sel_fall)
      begin
        state_reg <= SEF_OPCODE;
        bit_cnt_reg <= 3'h0;
        addr_cnt_reg <= 2'h0;
        data_seen_reg <= 1'b0;
        stat_got_reg <= 1'b0;
        wp_abort_reg <= 1'b0;
        drive_reg <= 1'b0;
      end
      else
      begin
        if (wp_fell && prot_reg.pin_protect_enable_bit)
        begin
          wp_abort_reg <= 1'b1;
        end
        if (sck_rise && state_reg != SEF_IGNORE)
        begin
          shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done)
        begin
          case (state_reg)
            SEF_OPCODE:
            begin
              if (!wel_reg && is_write_op && !busy_reg)
              begin
                state_reg <= SEF_IGNORE;
              end
              else
              begin
                state_reg <= op_state;
              end
              tx_reg <= status_byte;
            end
            SEF_STAT_OUT:
            begin
              tx_reg <= status_byte;
            end
            SEF_STAT_IN:
            begin
              stat_in_reg <= rx_byte;
              stat_got_reg <= 1'b1;
            end
            SEF_ADDR:
            begin
              addr_cnt_reg <= addr_cnt_reg + 2'h1;
              if (addr_cnt_reg == `SEF_ADDR_BYTES - 2'h1)
              begin
                state_reg <= data_seen_reg ? SEF_WR_DATA : SEF_RD_DATA;
                tx_reg <= rd_byte_i;
                rd_req_reg <= 1'b1;
              end
            end
            SEF_WR_DATA:
            begin
              data_seen_reg <= 1'b1;
            end
            SEF_RD_DATA:
            begin
              tx_reg <= rd_byte_i;
              rd_req_reg <= 1'b1;
            end
            default:
            begin
            end
          endcase
        end
        if (byte_done && state_reg == SEF_OPCODE)
        begin
          data_seen_reg <= is_write_op;
        end
        else if (byte_done && state_reg == SEF_ADDR && addr_cnt_reg == `SEF_ADDR_BYTES - 2'h1)
        begin
          data_seen_reg <= 1'b0;
        end
        if (sck_fall && tx_state)
        begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          drive_reg <= 1'b1;
        end
      end
    end
  end

  // Output pin: value changes on the falling serial clock edge only.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      so_reg <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else
    begin
      if (sck_fall && tx_state)
      begin
        so_reg <= tx_reg[7];
      end
      so_oe_o <= active && drive_reg && tx_state && !sel_rise;
    end
  end
  assign so_o = so_reg;

  // Protection state and the self-timed write cycle.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wel_reg <= 1'b0;
      prot_reg <= '0;
      busy_reg <= 1'b0;
      wc_cnt_reg <= 32'h0;
    end
    else
    begin
      if (stat_commit || arr_commit)
      begin
        busy_reg <= 1'b1;
        wc_cnt_reg <= 32'(WRITE_CYCLE_CLKS);
      end
      else if (wc_done)
      begin
        busy_reg <= 1'b0;
        wc_cnt_reg <= 32'h0;
        wel_reg <= 1'b0;
      end
      else if (busy_reg)
      begin
        wc_cnt_reg <= wc_cnt_reg - 32'h1;
      end
      if (stat_commit)
      begin
        prot_reg.pin_protect_enable_bit <= stat_in_reg[`SEF_ST_PEN];
        prot_reg.block_protect_hi <= stat_in_reg[`SEF_ST_BP_HI];
        prot_reg.block_protect_lo <= stat_in_reg[`SEF_ST_BP_LO];
      end
      if (byte_done && state_reg == SEF_OPCODE && !busy_reg)
      begin
        if (op_is(rx_byte, `SEF_OP_SET_WEL))
        begin
          wel_reg <= 1'b1;
        end
        else if (op_is(rx_byte, `SEF_OP_CLR_WEL))
        begin
          wel_reg <= 1'b0;
        end
      end
    end
  end
  assign busy_o = busy_reg;

  // Received bytes wait here until the FIFO takes them; a byte arriving first overwrites it.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      push_reg <= 1'b0;
      push_data_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      if (byte_done && (state_reg == SEF_ADDR || state_reg == SEF_WR_DATA))
      begin
        push_reg <= 1'b1;
        push_data_reg <= rx_byte;
      end
      else if (fifo_in_ready)
      begin
        push_reg <= 1'b0;
      end
      if (!rx_valid_reg || rx_ready_i)
      begin
        rx_valid_reg <= fifo_out_valid;
        rx_data_reg <= fifo_out_data;
      end
    end
  end
  assign rx_data_o = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign rd_req_o = rd_req_reg;

  wire fifo_pop = !rx_valid_reg || rx_ready_i;
  sef_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(push_data_reg),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop)
  );
endmodule

// ===== sef_front_end_chk.sv
// Concurrent checks on the ports of the serial EEPROM command front end.
`timescale 1ns/1ps
module sef_front_end_chk #(
  parameter int WRITE_CYCLE_CLKS = 320000,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link pins.
  input wire sef_pkg::sef_pins_t pins_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  // Byte streams and write cycle.
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] rd_byte_i,
  input wire logic rd_req_o,
  input wire logic busy_o
);
  import sef_pkg::*;
  int busy_cnt_reg;
  // The counter holds the number of busy cycles seen, so the fall can be tied to the exact length.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      busy_cnt_reg <= 0;
    else
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 1 : 0;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  deselect_quiet_a: assert property (pins_i.select_n [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  pause_quiet_a: assert property (!pins_i.pause_n [*6] |-> !so_oe_o)
    else $error("output driven while paused");
  // The enable lags the pins by the synchroniser and its own register, three cycles in all.
  drive_when_sel_a: assert property ($rose(so_oe_o) |-> !$past(pins_i.select_n, 3) && $past(pins_i.pause_n, 3))
    else $error("output enabled outside an active frame");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte dropped under back pressure");
  busy_length_a: assert property (!busy_o && $past(busy_o) |-> busy_cnt_reg == WRITE_CYCLE_CLKS)
    else $error("write cycle length wrong");
  busy_bound_a: assert property (busy_cnt_reg <= WRITE_CYCLE_CLKS)
    else $error("write cycle overran");
  rd_req_pulse_a: assert property (rd_req_o |=> !rd_req_o)
    else $error("read request longer than one cycle");
  commit_deselect_a: assert property ($rose(busy_o) |-> pins_i.select_n)
    else $error("write cycle began inside a frame");
endmodule
bind sef_front_end sef_front_end_chk #(.WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pins_i(pins_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rd_byte_i(rd_byte_i),
  .rd_req_o(rd_req_o), .busy_o(busy_o));

// ===== sef_spi_master.sv
// Behavioural serial link master that drives the front end's pins in mode 0.
`timescale 1ns/1ps
module sef_spi_master (
  input wire logic sys_clk_i,
  input wire logic so_i,
  output sef_pkg::sef_pins_t pins_o
);
  import sef_pkg::*;
  // The link clock idles low and only runs inside frames.
  initial pins_o = '{select_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
  // Half a link clock period of 100 ns, always ending just after a system clock edge.
  task automatic half();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic sel(input logic lvl);
    half();
    pins_o.select_n = lvl;
    // A released data line must not keep its last value.
    if (lvl)
      pins_o.si = ~pins_o.si;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      pins_o.sck = 1'b0;
      pins_o.si = tx[i];
      half();
      pins_o.sck = 1'b1;
      half();
      rx[i] = so_i;
    end
    pins_o.sck = 1'b0;
  endtask
  task automatic pause(input logic lvl);
    // Pause moves well inside the low phase, never together with a clock edge.
    half();
    pins_o.pause_n = lvl;
    half();
  endtask
  task automatic toggle(input int n);
    repeat (n)
    begin
      pins_o.sck = 1'b1;
      half();
      pins_o.sck = 1'b0;
      half();
    end
  endtask
  task automatic set_wp(input logic lvl);
    pins_o.wp_n = lvl;
    half();
  endtask
endmodule

// ===== sef_front_end_bench.sv
// Self-checking bench for the serial EEPROM command front end.
`timescale 1ns/1ps
`include "sef_map.svh"
module sef_front_end_bench;
  import sef_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  sef_pins_t pins;
  logic so_o, so_oe_o, rx_valid_o, rd_req_o, busy_o;
  logic rx_ready_i = 1'b0;
  logic [7:0] rx_data_o, r;
  logic [7:0] rd_byte_i = 8'h5a;
  logic [7:0] rb;
  // A released output line shows the opposite of its last bit, so a missing enable cannot pass.
  wire so_line = so_oe_o ? so_o : !so_o;
  logic [7:0] ex [4] = '{8'h01, 8'h23, 8'h45, 8'h9c};
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sef_front_end #(.WRITE_CYCLE_CLKS(400), .FIFO_DEPTH(4)) u_sef_front_end (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .pins_i(pins), .so_o(so_o), .so_oe_o(so_oe_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rd_byte_i(rd_byte_i), .rd_req_o(rd_req_o), .busy_o(busy_o));
  sef_spi_master u_m (.sys_clk_i(sys_clk_i), .so_i(so_line), .pins_o(pins));
  // Array side: the next read byte is presented just after each request.
  always @(posedge sys_clk_i)
  begin
    #1;
    if (rd_req_o === 1'b1)
      rd_byte_i = rd_byte_i + 8'h11;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input bit nd);
    u_m.sel(1'b0);
    u_m.xfer(op, r);
    if (nd)
      u_m.xfer(d, r);
    u_m.sel(1'b1);
  endtask
  task automatic rd_st(input logic [7:0] e, input logic [7:0] m);
    logic oe;
    u_m.sel(1'b0);
    u_m.xfer(`SEF_OP_STAT_RD, r);
    u_m.xfer(8'h00, r);
    oe = so_oe_o;
    u_m.sel(1'b1);
    check("status", r & m, e);
    check("oe in frame", {7'h0, oe}, 8'h01);
    check("oe after frame", {7'h0, so_oe_o}, 8'h00);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy_o !== 1'b0; i++)
      @(posedge sys_clk_i);
    #1;
    check("idle", {7'h0, busy_o}, 8'h00);
  endtask
  task automatic pop(input logic [7:0] e);
    for (int i = 0; i < 100 && rx_valid_o !== 1'b1; i++)
      @(posedge sys_clk_i);
    #1;
    check("rx valid", {7'h0, rx_valid_o}, 8'h01);
    check("rx byte", rx_data_o, e);
    rx_ready_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    rx_ready_i = 1'b0;
  endtask
  always @(posedge sys_clk_i)
  begin
    cycles++;
    // Roughly four times the expected run, so a hang ends the run without hiding slow cases.
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    rd_st(8'h00, 8'hff);
    cmd(8'h0e, 8'h00, 0);
    rd_st(8'h02, 8'hff);
    u_m.set_wp(1'b0);
    cmd(8'h0c, 8'h00, 0);
    rd_st(8'h00, 8'hff);
    u_m.set_wp(1'b1);
    cmd(`SEF_OP_SET_WEL, 8'h00, 0);
    cmd(`SEF_OP_STAT_WR, 8'h8c, 1);
    rd_st(8'hff, 8'hff);
    cmd(`SEF_OP_SET_WEL, 8'h00, 0);
    wait_idle();
    rd_st(8'h8c, 8'hff);
    u_m.set_wp(1'b0);
    cmd(`SEF_OP_SET_WEL, 8'h00, 0);
    cmd(8'h09, 8'h00, 1);
    check("refused busy", {7'h0, busy_o}, 8'h00);
    rd_st(8'h8c, 8'hfc);
    u_m.set_wp(1'b1);
    u_m.sel(1'b0);
    u_m.xfer(`SEF_OP_STAT_WR, r);
    u_m.xfer(8'h00, r);
    u_m.set_wp(1'b0);
    u_m.set_wp(1'b1);
    u_m.sel(1'b1);
    rd_st(8'h8c, 8'hfd);
    cmd(`SEF_OP_STAT_WR, 8'h00, 1);
    wait_idle();
    u_m.set_wp(1'b0);
    cmd(`SEF_OP_SET_WEL, 8'h00, 0);
    cmd(`SEF_OP_STAT_WR, 8'h0c, 1);
    wait_idle();
    rd_st(8'h0c, 8'hff);
    u_m.sel(1'b0);
    u_m.xfer(8'ha5, r);
    u_m.xfer(`SEF_OP_STAT_RD, r);
    check("bad opcode oe", {7'h0, so_oe_o}, 8'h00);
    u_m.sel(1'b1);
    u_m.sel(1'b0);
    u_m.xfer(`SEF_OP_STAT_RD, r);
    u_m.pause(1'b0);
    u_m.toggle(3);
    check("paused oe", {7'h0, so_oe_o}, 8'h00);
    u_m.pause(1'b1);
    u_m.xfer(8'h00, r);
    u_m.sel(1'b1);
    check("resumed status", r, 8'h0c);
    u_m.set_wp(1'b1);
    cmd(`SEF_OP_SET_WEL, 8'h00, 0);
    u_m.sel(1'b0);
    u_m.xfer(`SEF_OP_ARR_WR, r);
    for (int i = 0; i < 4; i++)
      u_m.xfer(ex[i], r);
    u_m.sel(1'b1);
    check("array write busy", {7'h0, busy_o}, 8'h01);
    for (int i = 0; i < 4; i++)
      pop(ex[i]);
    wait_idle();
    u_m.sel(1'b0);
    rb = rd_byte_i;
    u_m.xfer(`SEF_OP_ARR_RD, r);
    for (int i = 0; i < 3; i++)
      u_m.xfer(ex[i], r);
    u_m.xfer(8'h00, r);
    check("array read", r, rb);
    u_m.xfer(8'h00, r);
    u_m.sel(1'b1);
    check("array read next", r, rb + 8'h11);
    for (int i = 0; i < 3; i++)
      pop(ex[i]);
    print_verdict();
  end
endmodule
